// File: include/acc_pkg.sv
// What this block does
// - Twelve inputs on small variant, sixteen on large, one shared input mux
// - Sample selected input onto hold, resolve by successive approximation to 10 bits
// - References selectable between supply rails and two reference pins
// - Conversion may run in sleep only with the internal RC clock
// - Channel select in bits 7-4, code n picks input n
// - Control bits 3 and 1 ignore writes and read zero
// - Control register at 14h of bank 5, implemented bits reset to zero
// - Config register sets each shared pin analog or digital
// - Inputs 0 and 1 double as external reference pins
// - Seven registers: two control, result high and low, status, mask, bank
// - On completion load results, clear start bit, set done flag
// - Conversion takes 12 bit periods from start
// - Clock select: 00 /8, 01 /32, 10 /64, 11 internal RC
`default_nettype none
package acc_pkg;
    // ---------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------
    localparam logic [7:0] ACC_CTRL_OFF = 8'h14;
    localparam logic [7:0] ACC_CFG_OFF = 8'h15;
    localparam logic [7:0] ACC_RESH_OFF = 8'h18;
    localparam logic [7:0] ACC_RESL_OFF = 8'h1c;
    localparam logic [7:0] ACC_STAT_OFF = 8'h20;
    localparam logic [7:0] ACC_MASK_OFF = 8'h24;
    localparam logic [7:0] ACC_BANK_OFF = 8'h28;
    localparam logic [3:0] ACC_BANK_NUM = 4'h5;
    localparam logic [7:0] ACC_CTRL_RST = 8'h00;
    localparam logic [7:0] ACC_CFG_RST = 8'h00;
    // ---------------------------------------------
    // Fields
    // ---------------------------------------------
    localparam int ACC_CHS_LSB = 4;
    localparam int ACC_GO_BIT = 2;
    localparam int ACC_ON_BIT = 0;
    localparam int ACC_CS_LSB = 6;
    localparam int ACC_FMT_BIT = 5;
    localparam int ACC_PCFG_LSB = 1;
    localparam int ACC_VREF_BIT = 0;
    localparam logic [7:0] ACC_CTRL_WMASK = 8'hf5;
    localparam logic [7:0] ACC_CFG_WMASK = 8'hef;
    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int ACC_BITS = 10;
    localparam int ACC_CONV_TAD = 12;
    localparam int ACC_DIV8 = 8;
    localparam int ACC_DIV32 = 32;
    localparam int ACC_DIV64 = 64;
    localparam int ACC_RC_DIV = 16;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01
    } acc_state_e;
endpackage : acc_pkg
`default_nettype wire

// File: hw/acc_sar.sv
`default_nettype none
module acc_sar #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic step,
    input wire logic comp_in,
    // Result
    output logic [WIDTH-1:0] trial,
    output logic [WIDTH-1:0] result
);
    logic [WIDTH-1:0] trial_reg, trial_next, bit_reg, bit_next;
    always_comb begin
        trial_next = trial_reg;
        bit_next = bit_reg;
        if (start) begin
            bit_next = {1'b1, {(WIDTH-1){1'b0}}};
            trial_next = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (step && bit_reg != '0) begin
            // Keep or drop the trial bit, then try the next one
            if (!comp_in)
                trial_next = trial_reg & ~bit_reg;
            bit_next = bit_reg >> 1;
            trial_next = trial_next | (bit_reg >> 1);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial_reg <= '0;
            bit_reg <= '0;
        end else begin
            trial_reg <= trial_next;
            bit_reg <= bit_next;
        end
    end
    assign trial = trial_reg;
    assign result = trial_reg;
endmodule // acc_sar
`default_nettype wire

// File: hw/acc_top.sv
// The APB register port was left to the implementer.
`default_nettype none
module acc_top #(
    parameter int CHANNELS = 16
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog front end
    input wire logic comp_in,
    input wire logic rc_tick,
    input wire logic sleep_mode,
    output logic [3:0] mux_sel,
    output logic hold_sample,
    output logic conv_power,
    output logic [acc_pkg::ACC_BITS-1:0] dac_code,
    output logic ref_ext_sel,
    output logic [15:0] pin_analog,
    // Interrupt
    output logic irq
);
    import acc_pkg::*;
    if (CHANNELS != 12 && CHANNELS != 16) begin : g_bad_channels
        $error("CHANNELS must be 12 or 16");
    end
    // ---------------------------------------------
    // State
    // ---------------------------------------------
    acc_state_e st_reg, st_next;
    logic [7:0] ctrl_reg, ctrl_next, cfg_reg, cfg_next;
    logic [3:0] bank_reg, bank_next;
    logic [9:0] res_reg, res_next;
    logic stat_reg, stat_next, mask_reg, mask_next;
    logic [6:0] div_reg, div_next;
    logic [3:0] tad_reg, tad_next;
    logic [31:0] rd_reg, rd_next;
    logic slv_reg, slv_next, rdy_reg, rdy_next;
    logic [15:0] ana_reg, ana_next;
    logic [6:0] div_max;
    logic tick, wr, rd_acc, sar_start, sar_step, done, bank_ok, hit;
    logic [9:0] sar_trial, sar_res;
    // Writes commit on the edge that also shows pready high
    assign wr = psel && penable && pwrite && rdy_reg;
    assign hit = paddr inside {ACC_CTRL_OFF, ACC_CFG_OFF, ACC_RESH_OFF, ACC_RESL_OFF,
        ACC_STAT_OFF, ACC_MASK_OFF, ACC_BANK_OFF};
    assign rd_acc = psel && penable && !pwrite && !rdy_reg;
    assign bank_ok = bank_reg == ACC_BANK_NUM;
    // Clock select
    always_comb begin
        unique case (cfg_reg[ACC_CS_LSB +: 2])
            2'b00: div_max = 7'(ACC_DIV8 - 1);
            2'b01: div_max = 7'(ACC_DIV32 - 1);
            2'b10: div_max = 7'(ACC_DIV64 - 1);
            2'b11: div_max = 7'(ACC_RC_DIV - 1);
        endcase
    end
    // Only RC clock keeps ticking in sleep
    assign tick = (cfg_reg[ACC_CS_LSB +: 2] == 2'b11) ? rc_tick :
                  (!sleep_mode && div_reg == div_max);
    assign sar_start = st_reg == ACC_IDLE && st_next == ACC_CONV;
    assign sar_step = st_reg == ACC_CONV && tick && tad_reg >= 4'd1 && tad_reg <= 4'd10;
    assign done = st_reg == ACC_CONV && tick && tad_reg == 4'(ACC_CONV_TAD - 1);
    // ---------------------------------------------
    // Registers and conversion
    // ---------------------------------------------
    always_comb begin
        st_next = st_reg;
        ctrl_next = ctrl_reg;
        cfg_next = cfg_reg;
        bank_next = bank_reg;
        res_next = res_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        div_next = (st_reg == ACC_CONV && div_reg != div_max) ? div_reg + 7'd1 : 7'd0;
        tad_next = tad_reg;
        if (st_reg == ACC_CONV && tick)
            tad_next = tad_reg + 4'd1;
        if (wr) begin
            if (paddr == ACC_CTRL_OFF && bank_ok) begin
                ctrl_next = pwdata[7:0] & ACC_CTRL_WMASK;
                if (st_reg == ACC_CONV)
                    ctrl_next[ACC_GO_BIT] = ctrl_reg[ACC_GO_BIT];
            end else if (paddr == ACC_CFG_OFF && bank_ok)
                cfg_next = pwdata[7:0] & ACC_CFG_WMASK;
            else if (paddr == ACC_STAT_OFF && pwdata[0])
                stat_next = 1'b0;
            else if (paddr == ACC_MASK_OFF)
                mask_next = pwdata[0];
            else if (paddr == ACC_BANK_OFF)
                bank_next = pwdata[3:0];
        end
        // Power off aborts and blocks starts
        if (!ctrl_next[ACC_ON_BIT]) begin
            ctrl_next[ACC_GO_BIT] = 1'b0;
            st_next = ACC_IDLE;
        end else if (st_reg == ACC_IDLE && ctrl_next[ACC_GO_BIT]) begin
            st_next = ACC_CONV;
            tad_next = 4'd0;
        end
        if (done && ctrl_next[ACC_ON_BIT]) begin
            res_next = sar_res;
            ctrl_next[ACC_GO_BIT] = 1'b0;
            stat_next = 1'b1; // Set wins over clear
            st_next = ACC_IDLE;
        end
    end
    // ---------------------------------------------
    // Read path
    // ---------------------------------------------
    always_comb begin
        rd_next = 32'h0;
        slv_next = 1'b0;
        rdy_next = psel && penable && !rdy_reg;
        if (rd_acc) begin
            unique case (paddr)
                ACC_CTRL_OFF: rd_next[7:0] = bank_ok ? ctrl_reg : 8'h00;
                ACC_CFG_OFF: rd_next[7:0] = bank_ok ? cfg_reg : 8'h00;
                // Justification per format bit
                ACC_RESH_OFF: rd_next[7:0] = cfg_reg[ACC_FMT_BIT] ?
                    {6'h00, res_reg[9:8]} : res_reg[9:2];
                ACC_RESL_OFF: rd_next[7:0] = cfg_reg[ACC_FMT_BIT] ?
                    res_reg[7:0] : {res_reg[1:0], 6'h00};
                ACC_STAT_OFF: rd_next[0] = stat_reg;
                ACC_MASK_OFF: rd_next[0] = mask_reg;
                ACC_BANK_OFF: rd_next[3:0] = bank_reg;
                default: slv_next = 1'b1;
            endcase
        end else if (psel && penable && pwrite && !rdy_reg)
            slv_next = !hit;
    end
    // Per-pin analog/digital map, inputs 0 and 1 analog for refs under every code except 7
    generate
        for (genvar i = 0; i < 16; i++) begin : g_pin
            localparam int HALF = i % 8;
            assign ana_next[i] = (i < CHANNELS) &&
                (HALF < 8 - int'(cfg_next[ACC_PCFG_LSB +: 3])) &&
                (cfg_next[ACC_PCFG_LSB +: 3] != 3'b111);
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ACC_IDLE;
            ctrl_reg <= ACC_CTRL_RST;
            cfg_reg <= ACC_CFG_RST;
            bank_reg <= 4'h0;
            res_reg <= 10'h000;
            stat_reg <= 1'b0;
            mask_reg <= 1'b0;
            div_reg <= 7'd0;
            tad_reg <= 4'd0;
            rd_reg <= 32'h0;
            slv_reg <= 1'b0;
            rdy_reg <= 1'b0;
            ana_reg <= 16'h0000;
            mux_sel <= 4'h0;
            hold_sample <= 1'b0;
            conv_power <= 1'b0;
            dac_code <= 10'h000;
            ref_ext_sel <= 1'b0;
            irq <= 1'b0;
        end else begin
            st_reg <= st_next;
            ctrl_reg <= ctrl_next;
            cfg_reg <= cfg_next;
            bank_reg <= bank_next;
            res_reg <= res_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            div_reg <= div_next;
            tad_reg <= tad_next;
            rd_reg <= rd_next;
            slv_reg <= slv_next;
            rdy_reg <= rdy_next;
            ana_reg <= ana_next;
            // Reserved codes are software's duty on the small part
            mux_sel <= ctrl_next[ACC_CHS_LSB +: 4];
            // Hold switch closed while powered and idle, opened during conversion
            hold_sample <= ctrl_next[ACC_ON_BIT] && st_next == ACC_IDLE;
            conv_power <= ctrl_next[ACC_ON_BIT];
            dac_code <= sar_trial;
            ref_ext_sel <= cfg_next[ACC_VREF_BIT];
            irq <= stat_next && mask_next;
        end
    end
    assign prdata = rd_reg;
    assign pready = rdy_reg;
    assign pslverr = slv_reg;
    assign pin_analog = ana_reg;
    // Two idle periods after done are software's job
    acc_sar #(
        .WIDTH(ACC_BITS)
    ) u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(sar_start),
        .step(sar_step),
        .comp_in(comp_in),
        .trial(sar_trial),
        .result(sar_res)
    );
endmodule // acc_top
`default_nettype wire

// File: tb/acc_top_monitor.sv
`default_nettype none
module acc_top_monitor #(
    parameter int CHANNELS = 16
) (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Front end
    input wire logic [3:0] mux_sel,
    input wire logic conv_power,
    input wire logic ref_ext_sel,
    input wire logic [15:0] pin_analog,
    input wire logic irq
);
    import acc_pkg::*;
    // ----
    // Bank tracking, since ctrl and cfg only decode in bank 5
    // ----
    logic [3:0] bank_reg, bank_next;
    logic take, acc, ctl_wr, cfg_wr;
    // Writes land on the edge that samples pready high
    assign take = psel && penable && pready;
    assign acc = psel && penable && !pready;
    assign ctl_wr = take && pwrite && bank_reg == ACC_BANK_NUM && paddr == ACC_CTRL_OFF;
    assign cfg_wr = take && pwrite && bank_reg == ACC_BANK_NUM && paddr == ACC_CFG_OFF;
    always_comb begin
        bank_next = bank_reg;
        if (take && pwrite && paddr == ACC_BANK_OFF) begin
            bank_next = pwdata[3:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_reg <= 4'h0;
        end else begin
            bank_reg <= bank_next;
        end
    end
    function automatic logic [15:0] pins(input logic [2:0] k);
        logic [7:0] h;
        h = (k == 3'h7) ? 8'h00 : (8'hff >> k);
        return {h, h} & ((CHANNELS == 12) ? 16'h0fff : 16'hffff);
    endfunction
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer; acc |=> pready ##1 !pready; endproperty
    a_answer: assert property (p_answer) else $error("bus answer late or long");
    property p_unmapped;
        pready && !(paddr inside {8'h14, 8'h15, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28})
            |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_rsvd;
        pready && !pwrite && paddr == ACC_CTRL_OFF |-> !prdata[3] && !prdata[1];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("ctrl spare bits read one");
    property p_chan; ctl_wr |=> mux_sel == $past(pwdata[7:4]); endproperty
    a_chan: assert property (p_chan) else $error("channel not applied");
    property p_power; ctl_wr |=> conv_power == $past(pwdata[0]); endproperty
    a_power: assert property (p_power) else $error("power bit not applied");
    property p_ref; cfg_wr |=> ref_ext_sel == $past(pwdata[0]); endproperty
    a_ref: assert property (p_ref) else $error("reference select not applied");
    property p_pins; cfg_wr |=> pin_analog == pins($past(pwdata[3:1])); endproperty
    a_pins: assert property (p_pins) else $error("pin map wrong");
    property p_irq_off; $rose(irq) |-> conv_power; endproperty
    a_irq_off: assert property (p_irq_off) else $error("done while powered off");
    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
    c_cfg: cover property (cfg_wr);
endmodule // acc_top_monitor
bind acc_top acc_top_monitor #(.CHANNELS(CHANNELS)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mux_sel(mux_sel),
    .conv_power(conv_power), .ref_ext_sel(ref_ext_sel), .pin_analog(pin_analog), .irq(irq));
`default_nettype wire

// File: tb/acc_front_model.sv
`default_nettype none
module acc_front_model (
    // Converter side
    input wire logic pclk,
    input wire logic [3:0] mux_sel,
    input wire logic conv_power,
    input wire logic hold_sample,
    input wire logic [acc_pkg::ACC_BITS-1:0] dac_code,
    output logic comp_in
);
    import acc_pkg::*;
    logic [ACC_BITS-1:0] level, held = '0, src;
    logic junk = 1'b0;
    // Each input sits at a distinct level so a wrong channel shows
    assign level = {mux_sel, 6'h15};
    assign src = hold_sample ? level : held;
    always @(posedge pclk) begin
        junk <= ~junk;
        if (hold_sample) begin
            held <= level;
        end
    end
    // Unpowered comparator gives garbage, not a kind constant
    assign comp_in = conv_power ? (src >= dac_code) : junk;
endmodule // acc_front_model
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rc_tick = 0, sleep_mode = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, comp_in, hold_sample, conv_power, ref_ext_sel, irq, err;
    logic [3:0] mux_sel;
    logic [9:0] dac_code, lvl;
    logic [15:0] pin_analog;
    int error_cnt = 0, check_count = 0, rc_cnt = 0, n, dv;
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        rc_cnt <= (rc_cnt + 1) % 16;
        rc_tick <= (rc_cnt == 15);
    end
    acc_top #(.CHANNELS(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_in(comp_in), .rc_tick(rc_tick),
        .sleep_mode(sleep_mode), .mux_sel(mux_sel), .hold_sample(hold_sample),
        .conv_power(conv_power), .dac_code(dac_code), .ref_ext_sel(ref_ext_sel),
        .pin_analog(pin_analog), .irq(irq));
    acc_front_model fe (.pclk(pclk), .mux_sel(mux_sel), .conv_power(conv_power),
        .hold_sample(hold_sample), .dac_code(dac_code), .comp_in(comp_in));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic test_done();
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1, ACC_BANK_OFF, 32'h5);
        apb(0, ACC_CTRL_OFF, 0); check("ctrl reset", rd, 0);
        apb(0, ACC_CFG_OFF, 0); check("cfg reset", rd, 0);
        apb(0, 8'h30, 0); check("unmapped", {err, rd[30:0]}, 32'h80000000);
        for (int c = 0; c < 16; c++) begin
            apb(1, ACC_CTRL_OFF, {c[3:0], 4'ha});
            @(posedge pclk);
            check("channel", 32'(mux_sel), c);
            apb(0, ACC_CTRL_OFF, 0); check("ctrl read", rd, {c[3:0], 4'h0});
        end
        apb(1, ACC_BANK_OFF, 32'h3);
        apb(1, ACC_CTRL_OFF, 32'h31);
        apb(0, ACC_CTRL_OFF, 0); check("ctrl off bank", rd, 0);
        apb(1, ACC_BANK_OFF, 32'h5);
        apb(0, ACC_CTRL_OFF, 0); check("other bank", rd, 32'hf0);
        apb(1, ACC_CTRL_OFF, 32'h04);
        repeat (200) @(posedge pclk);
        apb(0, ACC_CTRL_OFF, 0); check("go unpowered", rd, 0);
        apb(0, ACC_STAT_OFF, 0); check("no done", rd[0], 0);
        apb(1, ACC_MASK_OFF, 32'h1);
        for (int cs = 0; cs < 4; cs++) begin
            dv = (cs == 0) ? ACC_DIV8 : (cs == 1) ? ACC_DIV32 : (cs == 2) ? ACC_DIV64 : 16;
            lvl = {4'(cs * 5), 6'h15};
            apb(1, ACC_CFG_OFF, {cs[1:0], cs[0], 4'h0, 1'b1});
            @(posedge pclk);
            check("ref", 32'(ref_ext_sel), 1);
            check("pins", 32'(pin_analog), 32'hffff);
            // Only the RC clock may keep converting in sleep
            sleep_mode <= (cs == 3);
            // Select and acquire first, then start
            apb(1, ACC_CTRL_OFF, {lvl[9:6], 4'h1});
            apb(1, ACC_CTRL_OFF, {lvl[9:6], 4'h5});
            apb(0, ACC_CTRL_OFF, 0); check("busy", rd, {lvl[9:6], 4'h5});
            n = 0;
            while (irq !== 1'b1 && n < 2000) begin
                @(posedge pclk);
                n++;
            end
            // RC ticks are free running, so the first period may be short
            check("conv time", 32'(n <= 12 * dv - 3 && n >= 12 * dv - ((cs == 3) ? 18 : 3)), 1);
            apb(0, ACC_CTRL_OFF, 0); check("go cleared", rd, {lvl[9:6], 4'h1});
            apb(0, ACC_RESH_OFF, 0);
            check("res high", rd, cs[0] ? {30'h0, lvl[9:8]} : {24'h0, lvl[9:2]});
            apb(0, ACC_RESL_OFF, 0);
            check("res low", rd, cs[0] ? {24'h0, lvl[7:0]} : {24'h0, lvl[1:0], 6'h0});
            apb(1, ACC_STAT_OFF, 32'h1);
            @(posedge pclk);
            check("irq clear", 32'(irq), 0);
            repeat (2 * dv) @(posedge pclk);
        end
        sleep_mode <= 1'b0;
        apb(1, ACC_MASK_OFF, 32'h0);
        apb(1, ACC_CFG_OFF, 32'h02);
        @(posedge pclk);
        check("pins", 32'(pin_analog), 32'h7f7f);
        apb(1, ACC_CTRL_OFF, 32'h05);
        repeat (140) @(posedge pclk);
        apb(0, ACC_STAT_OFF, 0); check("masked done", {rd[0], irq}, 2'b10);
        apb(1, ACC_STAT_OFF, 32'h1);
        // Divided clocks stop in sleep, the conversion must stall
        sleep_mode <= 1'b1;
        apb(1, ACC_CTRL_OFF, 32'h05);
        repeat (140) @(posedge pclk);
        apb(0, ACC_CTRL_OFF, 0); check("sleep stall", rd, 32'h05);
        sleep_mode <= 1'b0;
        repeat (140) @(posedge pclk);
        apb(0, ACC_STAT_OFF, 0); check("wake done", rd[0], 1);
        test_done();
    end
endmodule // testbench
`default_nettype wire
